// file: pkg/thermal_alarm_pkg.sv
// shared constants and types for the thermal alarm block
package thermal_alarm_pkg;
    // fixed upper nibbles of the bus slave address
    localparam logic [3:0] PFX_SENSOR = 4'h3;
    localparam logic [3:0] PFX_EEPROM = 4'ha;
    localparam logic [3:0] PFX_PROTECT = 4'h6;
    // register pointers
    localparam logic [7:0] PTR_CONFIG = 8'h01;
    localparam logic [7:0] PTR_UPPER = 8'h02;
    localparam logic [7:0] PTR_LOWER = 8'h03;
    localparam logic [7:0] PTR_CRIT = 8'h04;
    localparam logic [7:0] PTR_TEMP = 8'h05;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [15:0] TRIP_RESET = 16'h0000;
    localparam logic [15:0] READ_ZERO = 16'h0000;
    localparam logic [7:0] EEPROM_IDLE_BYTE = 8'hff;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] IDX_COMMIT = 2'h2;
    localparam logic [1:0] IDX_FULL = 2'h3;
    // hysteresis in temperature lsbs of 0.0625 degC: 0, 1.5, 3, 6 degC
    localparam logic [3:0][13:0] HYST_STEPS = {14'h0060, 14'h0030, 14'h0018, 14'h0000};
    // synchroniser lanes: scl, sda, three address pins, high-voltage detect
    localparam int SYNC_BITS = 6;
    localparam logic [5:0] SYNC_RESET = 6'h03;

    typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} bus_state_t;
    typedef enum logic [1:0] {T_NONE, T_SENSOR, T_EEPROM, T_PROTECT} target_t;

    typedef struct packed {
        logic [4:0] spare;
        logic [1:0] hyst;
        logic shutdown;
        logic crit_lock;
        logic win_lock;
        logic clear_alarm_bit;
        logic status;
        logic out_enable;
        logic crit_only;
        logic active_high;
        logic int_mode;
    } config_t;
endpackage

// file: hdl/pin_sync.sv
// two-flop synchroniser, one lane per input bit
`timescale 1ns/10ps
module pin_sync
    import thermal_alarm_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // lanes
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
            always_ff @(posedge clock_i) begin
                if (!resetn_i) begin
                    stage1[i] <= RESET_VALUE[i];
                    sync_o[i] <= RESET_VALUE[i];
                end else begin
                    stage1[i] <= async_i[i];
                    sync_o[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule

// file: hdl/thermal_alarm_event_logic.sv
// two-wire slave, trip registers and alarm output of the temperature sensor
// Notes on behaviour
// [R01] address is fixed nibble plus three pins
// [R02] sensor answers only to its own prefix
// [R03] memory and protect prefixes are also answered
// [R04] address pins sampled at every start
// [R05] high voltage on pin zero sets protection
// [R06] bytes travel most significant bit first
// [R07] master alone makes the serial clock
// [R08] config bit zero picks interrupt or comparator
// [R09] config bit two picks critical-only band
// [R10] two-bit hysteresis lowers each trip point
// [R11] lock bits freeze window and critical trips
// [R12] alarm pin floats until enabled
// [R13] config bit one sets alarm polarity
// [R14] bit four reads status, bit five clears
// [R15] mode bits frozen while output enabled
// [R16] shutdown keeps an asserted alarm asserted
// [R17] temperature word carries three band flags
// [R18] above critical forces comparator behaviour
// [R19] window trips live at two pointers
// [R20] window crossing either way raises event
// [R21] status shows logical alarm state
// [R22] clear cannot drop alarm above critical
`timescale 1ns/10ps
module thermal_alarm_event_logic
    import thermal_alarm_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // two-wire bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // address straps
    input wire logic addr_select_pin_zero_i,
    input wire logic addr_select_pin_one_i,
    input wire logic addr_select_pin_two_i,
    input wire logic hv_detect_i,
    // converter result, same clock
    input wire logic [12:0] temp_i,
    // alarm pin and protection flag
    output logic event_o,
    output logic event_oe_o,
    output logic rwp_o
);
    logic [5:0] pins_sync;
    logic scl_q;
    logic sda_q;
    bus_state_t state;
    target_t target;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [1:0] byte_idx;
    logic read_mode;
    logic ack_en;
    logic ack_drive;
    logic [7:0] pointer;
    logic [7:0] msb_hold;
    logic [15:0] tx_word;
    logic [2:0] pins_latched;
    logic hv_latched;
    logic wr_stb;
    logic [15:0] wr_data;
    config_t cfg;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] crit;
    logic above_crit;
    logic above_win;
    logic below_win;
    logic win_out_q;
    logic crit_q;
    logic pend;
    logic asserted;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    pin_sync #(
        .WIDTH(SYNC_BITS),
        .RESET_VALUE(SYNC_RESET)
    ) u_pin_sync (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .async_i({hv_detect_i, addr_select_pin_two_i, addr_select_pin_one_i,
                  addr_select_pin_zero_i, sda_i, scl_i}),
        .sync_o(pins_sync)
    );

    wire scl_s = pins_sync[0];
    wire sda_s = pins_sync[1];
    wire [2:0] pins_s = pins_sync[4:2];
    wire hv_s = pins_sync[5];

    // bus edge and condition detect
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_det = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_det = scl_s & scl_q & ~sda_q & sda_s;
    wire [7:0] rx_byte = {shreg[6:0], sda_s};
    wire addr_ok = rx_byte[3:1] == pins_latched; // R01
    wire target_t rx_target = !addr_ok ? T_NONE :
                              rx_byte[7:4] == PFX_SENSOR ? T_SENSOR : // R02
                              rx_byte[7:4] == PFX_EEPROM ? T_EEPROM : // R03
                              rx_byte[7:4] == PFX_PROTECT ? T_PROTECT : T_NONE; // R03

    // register read view
    wire [15:0] cfg_view = {cfg[15:6], 1'b0, asserted, cfg[3:0]}; // R14 R21
    wire [15:0] temp_view = {above_crit, above_win, below_win, temp_i}; // R17
    wire [15:0] reg_rd = pointer == PTR_CONFIG ? cfg_view :
                         pointer == PTR_UPPER ? upper :
                         pointer == PTR_LOWER ? lower :
                         pointer == PTR_CRIT ? crit :
                         pointer == PTR_TEMP ? temp_view : READ_ZERO;
    // word is frozen at the first byte so a new conversion cannot tear it
    wire [15:0] tx_src = byte_idx == '0 ? reg_rd : tx_word;
    wire [7:0] tx_next = target != T_SENSOR ? EEPROM_IDLE_BYTE :
                         byte_idx[0] ? tx_src[7:0] : tx_src[15:8];

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    always_ff @(posedge clock_i) begin
        wr_stb <= 1'b0;
        if (!resetn_i) begin
            state <= S_IDLE;
            target <= T_NONE;
            bit_cnt <= '0;
            shreg <= '0;
            byte_idx <= '0;
            read_mode <= 1'b0;
            ack_en <= 1'b0;
            ack_drive <= 1'b0;
            pointer <= '0;
            msb_hold <= '0;
            tx_word <= '0;
            pins_latched <= '0;
            hv_latched <= 1'b0;
            wr_data <= '0;
            sda_oe_o <= 1'b0;
            rwp_o <= 1'b0;
        end else if (start_det) begin
            state <= S_RX;
            target <= T_NONE;
            bit_cnt <= '0;
            byte_idx <= '0;
            sda_oe_o <= 1'b0;
            pins_latched <= pins_s; // R04
            hv_latched <= hv_s;
        end else if (stop_det) begin
            state <= S_IDLE;
            sda_oe_o <= 1'b0;
        end else begin
            case (state)
                S_RX: begin
                    if (scl_rise) begin
                        shreg <= rx_byte; // R06
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == BIT_LAST) begin
                            state <= S_ACK;
                            ack_drive <= 1'b0;
                            if (target == T_NONE) begin
                                target <= rx_target;
                                read_mode <= rx_byte[0];
                                ack_en <= rx_target != T_NONE;
                                if (rx_target == T_PROTECT && !rx_byte[0] && hv_latched) begin
                                    rwp_o <= 1'b1; // R05
                                end
                            end else begin
                                ack_en <= 1'b1;
                                if (byte_idx != IDX_FULL) begin
                                    byte_idx <= byte_idx + 2'h1;
                                end
                                if (target == T_SENSOR && byte_idx == '0) begin
                                    pointer <= rx_byte;
                                end
                                if (target == T_SENSOR && byte_idx == IDX_COMMIT - 2'h1) begin
                                    msb_hold <= rx_byte;
                                end
                                if (target == T_SENSOR && byte_idx == IDX_COMMIT) begin
                                    wr_stb <= 1'b1;
                                    wr_data <= {msb_hold, rx_byte};
                                end
                            end
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall && !ack_drive) begin
                        ack_drive <= 1'b1;
                        sda_oe_o <= ack_en;
                    end else if (scl_fall) begin
                        ack_drive <= 1'b0;
                        bit_cnt <= '0;
                        if (!ack_en) begin
                            state <= S_IDLE;
                            sda_oe_o <= 1'b0;
                        end else if (read_mode) begin
                            state <= S_TX;
                            shreg <= tx_next;
                            tx_word <= tx_src;
                            sda_oe_o <= ~tx_next[7]; // R06
                        end else begin
                            state <= S_RX;
                            sda_oe_o <= 1'b0;
                        end
                    end
                end
                S_TX: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == BIT_LAST) begin
                            state <= S_MACK;
                            byte_idx <= byte_idx + 2'h1;
                        end
                    end else if (scl_fall) begin
                        shreg <= {shreg[6:0], 1'b0};
                        sda_oe_o <= ~shreg[6]; // R06
                    end
                end
                S_MACK: begin
                    if (scl_fall && !ack_drive) begin
                        sda_oe_o <= 1'b0;
                    end else if (scl_rise) begin
                        // master nack ends the read
                        state <= sda_s ? S_IDLE : S_MACK;
                        ack_drive <= ~sda_s;
                    end else if (scl_fall) begin
                        ack_drive <= 1'b0;
                        state <= S_TX;
                        shreg <= tx_next;
                        sda_oe_o <= ~tx_next[7];
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // register writes
    wire config_t wcfg = config_t'(wr_data);
    wire wr_cfg = wr_stb && pointer == PTR_CONFIG;
    wire wr_upper = wr_stb && pointer == PTR_UPPER;
    wire wr_lower = wr_stb && pointer == PTR_LOWER;
    wire wr_crit = wr_stb && pointer == PTR_CRIT;
    wire clear_req = wr_cfg && wcfg.clear_alarm_bit; // R14

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            cfg <= config_t'(CONFIG_RESET); // R12
            upper <= TRIP_RESET;
            lower <= TRIP_RESET;
            crit <= TRIP_RESET;
        end else begin
            if (wr_cfg) begin
                // mode and band stay put while the pin is enabled
                cfg.int_mode <= cfg.out_enable ? cfg.int_mode : wcfg.int_mode; // R08 R15
                cfg.crit_only <= cfg.out_enable ? cfg.crit_only : wcfg.crit_only; // R09 R15
                cfg.active_high <= wcfg.active_high; // R13
                cfg.out_enable <= wcfg.out_enable; // R12
                cfg.win_lock <= cfg.win_lock | wcfg.win_lock; // R11
                cfg.crit_lock <= cfg.crit_lock | wcfg.crit_lock; // R11
                cfg.shutdown <= wcfg.shutdown;
                cfg.hyst <= wcfg.hyst; // R10
            end
            if (wr_upper && !cfg.win_lock) begin
                upper <= wr_data; // R11 R19
            end
            if (wr_lower && !cfg.win_lock) begin
                lower <= wr_data; // R11 R19
            end
            if (wr_crit && !cfg.crit_lock) begin
                crit <= wr_data; // R11
            end
        end
    end

    // band comparisons, signed 13-bit temperatures widened by one bit
    logic signed [13:0] t_s;
    logic signed [13:0] hys_s;
    logic signed [13:0] crit_s;
    logic signed [13:0] up_s;
    logic signed [13:0] lo_s;
    assign t_s = {temp_i[12], temp_i};
    assign hys_s = HYST_STEPS[cfg.hyst]; // R10
    assign crit_s = {crit[12], crit[12:0]};
    assign up_s = {upper[12], upper[12:0]};
    assign lo_s = {lower[12], lower[12:0]};
    wire crit_set = t_s >= crit_s;
    wire crit_clr = t_s < crit_s - hys_s; // R10
    wire up_set = t_s > up_s;
    wire up_clr = t_s <= up_s - hys_s;
    wire lo_set = t_s < lo_s - hys_s;
    wire lo_clr = t_s >= lo_s;
    wire win_out = above_win | below_win;
    wire crossing = win_out ^ win_out_q;
    wire crit_fall = crit_q & ~above_crit;
    wire next_asserted = cfg.shutdown ? asserted : // R16
                         above_crit ? 1'b1 : // R18 R22
                         cfg.crit_only ? 1'b0 : // R09
                         cfg.int_mode ? pend : win_out; // R08

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            above_crit <= 1'b0;
            above_win <= 1'b0;
            below_win <= 1'b0;
            win_out_q <= 1'b0;
            crit_q <= 1'b0;
        end else begin
            above_crit <= crit_set | (above_crit & ~crit_clr); // R17
            above_win <= up_set | (above_win & ~up_clr); // R17
            below_win <= lo_set | (below_win & ~lo_clr); // R17
            win_out_q <= win_out;
            crit_q <= above_crit;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            pend <= 1'b0;
            asserted <= 1'b0;
            event_oe_o <= 1'b0;
            event_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            // a crossing in the clearing cycle still wins
            if (crossing && cfg.out_enable && cfg.int_mode && !cfg.crit_only) begin
                pend <= 1'b1; // R20
            end else if (clear_req || crit_fall) begin
                pend <= 1'b0; // R14 R22
            end
            asserted <= next_asserted;
            // open drain: pull low when the wanted level is low
            event_oe_o <= cfg.out_enable & (asserted ^ cfg.active_high); // R12 R13
        end
    end
    // scl edges never coincide with start or stop, so those terms are left out below
    a_pin_floats: assert property (!cfg.out_enable |=> !event_oe_o) // R12
        else $error("alarm pin driven while output disabled");
    a_crit_forces: assert property (above_crit && !cfg.shutdown |=> asserted) // R18
        else $error("alarm not asserted above critical trip");
    a_clear_blocked: assert property (clear_req && above_crit && !cfg.shutdown |=> above_crit |=> asserted) // R22
        else $error("clear dropped alarm above critical trip");
    a_status_level: assert property (pointer == PTR_CONFIG |-> reg_rd[4] == asserted && !reg_rd[5]) // R21
        else $error("status bit does not follow alarm state");
    a_window_lock: assert property (cfg.win_lock && (wr_upper || wr_lower) |=> $stable({upper, lower})) // R11
        else $error("locked window trip changed");
    a_mode_frozen: assert property (wr_cfg && cfg.out_enable |=> $stable({cfg.int_mode, cfg.crit_only})) // R15
        else $error("mode bits changed while output enabled");
    a_shutdown_hold: assert property (cfg.shutdown && asserted |=> asserted) // R16
        else $error("alarm released during shutdown");
    a_crossing_sets: assert property (crossing && cfg.out_enable && cfg.int_mode && !cfg.crit_only |=> pend) // R20
        else $error("window crossing did not raise event");
    a_addr_nack: assert property (state == S_RX && scl_rise && bit_cnt == BIT_LAST && target == T_NONE // R02
        && rx_target == T_NONE |=> state == S_ACK && !ack_en)
        else $error("foreign address was acknowledged");
    a_msb_first: assert property (state == S_TX && scl_fall |=> sda_oe_o == !$past(shreg[6])) // R06
        else $error("transmit bit order wrong");
    a_crit_hyst: assert property (above_crit && !crit_clr |=> above_crit) // R10
        else $error("critical flag dropped inside hysteresis");
endmodule

// file: test/twi_host_model.sv
// two-wire bus master model that makes the serial clock and data
`timescale 1ns/10ps
module twi_host_model (
    // bus lines, low on sda_drv_o pulls the line
    output logic scl_o,
    output logic sda_drv_o,
    input wire logic sda_i
);
    initial begin
        scl_o = 1'b1;
        sda_drv_o = 1'b1;
    end
    // 80 ns bit slot, clock stands high between frames
    task automatic slot(input logic b, output logic r);
        #20 sda_drv_o = b;
        #20 scl_o = 1'b1;
        #20 r = sda_i;
        #20 scl_o = 1'b0;
    endtask
    // long lead-in lets a late ack release; 20 ns steps keep every sda change away from an scl edge
    task automatic start();
        #40 sda_drv_o = 1'b1;
        #20 scl_o = 1'b1;
        #20 sda_drv_o = 1'b0;
        #20 scl_o = 1'b0;
    endtask
    task automatic stop();
        #20 sda_drv_o = 1'b0;
        #20 scl_o = 1'b1;
        #20 sda_drv_o = 1'b1;
        #20;
    endtask
    task automatic xfer(input logic [7:0] d, input logic m9, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            slot(d[i], r);
            q[i] = r;
        end
        slot(m9, r);
        ack = ~r;
    endtask
    task automatic wr16(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d, output logic ok);
        logic [7:0] q;
        logic k0, k1, k2, k3;
        start();
        xfer({a, 1'b0}, 1'b1, q, k0);
        xfer(p, 1'b1, q, k1);
        xfer(d[15:8], 1'b1, q, k2);
        xfer(d[7:0], 1'b1, q, k3);
        stop();
        ok = k0 & k1 & k2 & k3;
    endtask
    task automatic rd16(input logic [6:0] a, input logic [7:0] p, output logic [15:0] v, output logic ok);
        logic k0, k1, k2, k3;
        logic [7:0] q;
        start();
        xfer({a, 1'b0}, 1'b1, q, k0);
        xfer(p, 1'b1, q, k1);
        start();
        xfer({a, 1'b1}, 1'b1, q, k2);
        xfer(8'hff, 1'b0, v[15:8], k3);
        xfer(8'hff, 1'b1, v[7:0], k3);
        stop();
        ok = k0 & k1 & k2;
    endtask
endmodule

// file: test/tb_thermal_alarm_event_logic.sv
// self-checking bench for the thermal alarm block
`timescale 1ns/10ps
module tb_thermal_alarm_event_logic;
    import thermal_alarm_pkg::*;
    localparam logic [12:0] UP = 13'h0200;
    localparam logic [12:0] LO = 13'h0100;
    localparam logic [12:0] CR = 13'h0400;
    localparam logic [12:0] IN = 13'h0180;
    localparam logic [12:0] HI = 13'h0300;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [2:0] pins = 3'h0;
    logic hv = 1'b0;
    logic [12:0] temp = IN;
    logic scl, sda_drv, sda_o, sda_oe_o, event_o, event_oe_o, rwp_o, ok;
    logic [15:0] v;
    logic [15:0] r;
    wire logic sda = sda_drv & (sda_o | ~sda_oe_o);
    int err_count = 0;
    int num_checks = 0;
    int seed = 75117;
    always #5 clock_i = ~clock_i;
    thermal_alarm_event_logic uut (.clock_i(clock_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_select_pin_zero_i(pins[0]), .addr_select_pin_one_i(pins[1]),
        .addr_select_pin_two_i(pins[2]), .hv_detect_i(hv), .temp_i(temp), .event_o(event_o),
        .event_oe_o(event_oe_o), .rwp_o(rwp_o));
    twi_host_model host (.scl_o(scl), .sda_drv_o(sda_drv), .sda_i(sda));
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        chk_word({15'h0, got}, {15'h0, exp}, m);
    endtask
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        host.wr16({PFX_SENSOR, pins}, p, d, ok);
    endtask
    task automatic rd(input logic [7:0] p);
        host.rd16({PFX_SENSOR, pins}, p, v, ok);
    endtask
    task automatic settle(input logic [12:0] t);
        @(negedge clock_i);
        temp = t;
        repeat (6) @(negedge clock_i);
    endtask
    // memoryless only while hysteresis is zero
    function automatic logic [2:0] flags(input logic [12:0] t);
        return {$signed(t) >= $signed(CR), $signed(t) > $signed(UP), $signed(t) < $signed(LO)};
    endfunction
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #500us;
        err_count++;
        final_report();
    end
    initial begin
        repeat (5) @(negedge clock_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clock_i);
        chk_bit(event_oe_o, 1'b0, "alarm floats");
        chk_word({14'h0, event_o, sda_o}, 16'h0000, "open drain data low");
        for (int i = 0; i < 4; i++) begin
            @(negedge clock_i);
            pins = 3'($random(seed));
            wr(PTR_CONFIG, 16'h0000);
            chk_bit(ok, 1'b1, "own address");
            host.wr16({PFX_SENSOR, ~pins}, PTR_CONFIG, 16'h0000, ok);
            chk_bit(ok, 1'b0, "other pins");
        end
        host.wr16({4'h5, pins}, PTR_CONFIG, 16'h0000, ok);
        chk_bit(ok, 1'b0, "foreign prefix");
        host.rd16({PFX_EEPROM, pins}, 8'h00, v, ok);
        chk_word({15'h0, ok}, 16'h0001, "memory ack");
        chk_word(v, {EEPROM_IDLE_BYTE, EEPROM_IDLE_BYTE}, "memory data");
        host.wr16({PFX_PROTECT, pins}, 8'h00, 16'h0000, ok);
        chk_bit(rwp_o, 1'b0, "no protect at low level");
        @(negedge clock_i);
        hv = 1'b1;
        host.wr16({PFX_PROTECT, pins}, 8'h00, 16'h0000, ok);
        chk_bit(rwp_o, 1'b1, "protect set");
        @(negedge clock_i);
        hv = 1'b0;
        for (int i = 0; i < 3; i++) begin
            r = {3'h0, 13'($random(seed))};
            wr(PTR_UPPER + 8'(i % 2), r);
            rd(PTR_UPPER + 8'(i % 2));
            chk_word(v, r, "trip readback");
        end
        rd(8'h07);
        chk_word(v, READ_ZERO, "unmapped pointer");
        wr(PTR_UPPER, {3'h0, UP});
        wr(PTR_LOWER, {3'h0, LO});
        wr(PTR_CRIT, {3'h0, CR});
        for (int i = 0; i < 6; i++) begin
            settle(13'($random(seed)));
            rd(PTR_TEMP);
            chk_word(v, {flags(temp), temp}, "temperature word");
        end
        wr(PTR_CONFIG, 16'h0200);
        settle(UP + 13'h1);
        settle(UP - 13'h000a);
        rd(PTR_TEMP);
        chk_bit(v[14], 1'b1, "hysteresis holds flag");
        settle(UP - 13'h0018);
        rd(PTR_TEMP);
        chk_bit(v[14], 1'b0, "flag released");
        wr(PTR_CONFIG, 16'h0008);
        settle(IN);
        chk_bit(event_oe_o, 1'b0, "inside window");
        settle(HI);
        chk_bit(event_oe_o, 1'b1, "comparator asserts");
        rd(PTR_CONFIG);
        chk_bit(v[4], 1'b1, "status bit");
        settle(IN);
        chk_bit(event_oe_o, 1'b0, "comparator releases");
        wr(PTR_CONFIG, 16'h0000);
        wr(PTR_CONFIG, 16'h000a);
        settle(HI);
        chk_bit(event_oe_o, 1'b0, "active high asserted");
        rd(PTR_CONFIG);
        chk_bit(v[4], 1'b1, "status ignores polarity");
        settle(IN);
        chk_bit(event_oe_o, 1'b1, "active high idle");
        wr(PTR_CONFIG, 16'h0000);
        wr(PTR_CONFIG, 16'h0009);
        settle(HI);
        chk_bit(event_oe_o, 1'b1, "crossing out");
        wr(PTR_CONFIG, 16'h0029);
        chk_bit(event_oe_o, 1'b0, "cleared");
        settle(IN);
        chk_bit(event_oe_o, 1'b1, "crossing in");
        wr(PTR_CONFIG, 16'h0029);
        settle(CR);
        chk_bit(event_oe_o, 1'b1, "critical");
        wr(PTR_CONFIG, 16'h0029);
        chk_bit(event_oe_o, 1'b1, "clear refused above critical");
        settle(HI);
        chk_bit(event_oe_o, 1'b0, "left critical band");
        wr(PTR_CONFIG, 16'h0008);
        settle(IN);
        chk_bit(event_oe_o, 1'b1, "mode change ignored");
        wr(PTR_CONFIG, 16'h0029);
        wr(PTR_CONFIG, 16'h0000);
        wr(PTR_CONFIG, 16'h000c);
        settle(HI);
        chk_bit(event_oe_o, 1'b0, "window ignored");
        settle(CR);
        chk_bit(event_oe_o, 1'b1, "critical only");
        wr(PTR_CONFIG, 16'h010c);
        settle(IN);
        chk_bit(event_oe_o, 1'b1, "held in shutdown");
        wr(PTR_CONFIG, 16'h00c0);
        wr(PTR_UPPER, 16'h0123);
        rd(PTR_UPPER);
        chk_word(v, {3'h0, UP}, "window locked");
        wr(PTR_CRIT, 16'h0777);
        rd(PTR_CRIT);
        chk_word(v, {3'h0, CR}, "critical locked");
        final_report();
    end
endmodule
